//--- include/eirq_pkg.sv
// ==========================================================================
// external event line configuration constants
package eirq_pkg;

    // ======================================================================
    // clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned DEB_TIME_MS = 100;
    localparam int unsigned DEB_CYC = (CLK_HZ / 1000) * DEB_TIME_MS;
    localparam int unsigned MIN_PULSE_NS = 450;
    // least time, so round up
    localparam int unsigned MIN_PULSE_CYC =
        (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sync chain fill before edges count
    localparam logic [1:0] INIT_DONE = 2'h3;

    // ======================================================================
    // register map
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_ENABLE = 4'h2;
    localparam logic [3:0] OFS_CLEAR = 4'h3;
    localparam logic [3:0] OFS_LEVEL = 4'h4;
    localparam logic [15:0] CONFIG_RESET = 16'h0005;

    // ======================================================================
    // configuration fields
    localparam int unsigned LINES = 4;
    localparam int unsigned BIT_DEBOUNCE = 8;
    localparam int unsigned BIT_UART_WAKE = 9;
    localparam int unsigned BIT_PWM_SEL = 15;
    // status layout: lines 0..3, then wake
    localparam int unsigned STAT_W = 5;
    localparam int unsigned STAT_WAKE = 4;

endpackage : eirq_pkg

//--- hdl/eirq_edge_config.sv
// What this block does
// - Event lines 0 to 3 come from pins port A 0, port A 1, port B 0, port B 6 in that order.
// - Line 0 fires on a falling edge when config bit 0 is set and on a rising edge when bit 1 is set.
// - Line 1 fires on a falling edge when config bit 2 is set and on a rising edge when bit 3 is set.
// - Line 2 fires on a falling edge when config bit 4 is set and on a rising edge when bit 5 is set.
// - Line 3 fires on a falling edge when config bit 6 is set and on a rising edge when bit 7 is set.
// - Config bit 8 puts a 100 ms debounce on every event line before an edge is seen.
// - Without debounce, pulses of 450 ns or longer on the event pins are seen.
// - Config bit 9 lets activity on the serial receive pin wake the device from low power.
// - After such a wake the first received character is dropped.
// - Config bit 15 routes the PWM signal to the PWM capable pin, otherwise it stays ordinary I/O.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module eirq_edge_config #(
    parameter int unsigned DEB_CYC = eirq_pkg::DEB_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [eirq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [eirq_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [eirq_pkg::DATA_W-1:0] reg_rdata,
    // event pins
    input wire logic port_a_pin_0,
    input wire logic port_a_pin_1,
    input wire logic port_b_pin_0,
    input wire logic port_b_pin_6,
    // event outputs
    output logic ext_event_line_0,
    output logic ext_event_line_1,
    output logic ext_event_line_2,
    output logic ext_event_line_3,
    output logic irq,
    // serial receive and wake
    input wire logic uart_rx_pin,
    input wire logic low_power,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    output logic wake_req,
    output logic rx_pass_valid,
    output logic [7:0] rx_pass_data,
    // pwm capable pin
    input wire logic pwm_in,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic pwm_capable_pin_out,
    output logic pwm_capable_pin_oe
);

    localparam int unsigned NL = eirq_pkg::LINES;
    localparam int unsigned CW = $clog2(DEB_CYC + 1);
    localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYC - 1);

    // ======================================================================
    // state
    typedef struct packed {
        logic [NL-1:0] sync0;
        logic [NL-1:0] sync1;
        logic [NL-1:0] sync2;
        logic [NL-1:0] stable;
        logic [NL-1:0][CW-1:0] cnt;
        logic [1:0] init_cnt;
        logic [2:0] rx_sync;
        logic rx_level;
        logic [15:0] cfg;
        logic [eirq_pkg::STAT_W-1:0] status;
        logic [eirq_pkg::STAT_W-1:0] enable;
        logic [NL-1:0] evt;
        logic irq;
        logic [15:0] rdata;
        logic wake;
        logic discard;
        logic rxv;
        logic [7:0] rxd;
        logic pin_out;
        logic pin_oe;
    } eirq_state_t;

    eirq_state_t st_reg;
    eirq_state_t st_next;
    logic [NL-1:0] pins;

    // fixed pin order sets the line numbering
    assign pins = {port_b_pin_6, port_b_pin_0, port_a_pin_1, port_a_pin_0};

    // ======================================================================
    // helpers
    function automatic logic eirq_edge_hit(
        input logic old_lvl,
        input logic new_lvl,
        input logic fall_en,
        input logic rise_en
    );
        eirq_edge_hit = (old_lvl & ~new_lvl & fall_en)
            | (~old_lvl & new_lvl & rise_en);
    endfunction : eirq_edge_hit

    // ======================================================================
    // next state
    always_comb
    begin
        logic ready;
        logic rx_fall;
        logic [eirq_pkg::STAT_W-1:0] ev;
        logic [eirq_pkg::STAT_W-1:0] clr;
        ready = 1'b0;
        rx_fall = 1'b0;
        ev = '0;
        clr = '0;
        st_next = st_reg;
        // first stage feeds only the second
        st_next.sync0 = pins;
        st_next.sync1 = st_reg.sync0;
        st_next.sync2 = st_reg.sync1;
        ready = (st_reg.init_cnt == eirq_pkg::INIT_DONE);
        if (!ready)
        begin
            st_next.init_cnt = st_reg.init_cnt + 2'h1;
        end

        for (int i = 0; i < NL; i++)
        begin
            if (!ready)
            begin
                // adopt pin level silently while the chain fills
                st_next.stable[i] = st_reg.sync1[i];
                st_next.cnt[i] = '0;
            end
            else if (!st_reg.cfg[eirq_pkg::BIT_DEBOUNCE])
            begin
                // no filter: two-cycle agreement is far below 450 ns
                st_next.cnt[i] = '0;
                if (st_reg.sync1[i] == st_reg.sync2[i])
                begin
                    st_next.stable[i] = st_reg.sync2[i];
                end
            end
            else if (st_reg.sync2[i] == st_reg.stable[i])
            begin
                // bounce back restarts the interval
                st_next.cnt[i] = '0;
            end
            else if (st_reg.cnt[i] == DEB_LAST)
            begin
                st_next.stable[i] = st_reg.sync2[i];
                st_next.cnt[i] = '0;
            end
            else
            begin
                st_next.cnt[i] = st_reg.cnt[i] + CW'(1);
            end
            ev[i] = ready & eirq_edge_hit(st_reg.stable[i],
                st_next.stable[i], st_reg.cfg[2*i], st_reg.cfg[2*i+1]);
        end
        st_next.evt = ev[NL-1:0];

        // serial receive wake
        st_next.rx_sync = {st_reg.rx_sync[1:0], uart_rx_pin};
        if (st_reg.rx_sync[1] == st_reg.rx_sync[2])
        begin
            st_next.rx_level = st_reg.rx_sync[2];
        end
        rx_fall = st_reg.rx_level & ~st_next.rx_level;
        st_next.wake = rx_fall & low_power
            & st_reg.cfg[eirq_pkg::BIT_UART_WAKE];
        ev[eirq_pkg::STAT_WAKE] = st_next.wake;

        // the waking character is garbled, so it is dropped
        st_next.rxv = rx_char_valid & ~st_reg.discard;
        st_next.rxd = rx_char_data;
        if (st_reg.wake)
        begin
            st_next.discard = 1'b1;
        end
        else if (rx_char_valid)
        begin
            st_next.discard = 1'b0;
        end

        // pin mux
        if (st_reg.cfg[eirq_pkg::BIT_PWM_SEL])
        begin
            st_next.pin_out = pwm_in;
            st_next.pin_oe = 1'b1;
        end
        else
        begin
            st_next.pin_out = gpio_out;
            st_next.pin_oe = gpio_oe;
        end

        // register writes
        if (reg_wr)
        begin
            if (reg_addr == eirq_pkg::OFS_CONFIG)
            begin
                st_next.cfg = reg_wdata;
            end
            else if (reg_addr == eirq_pkg::OFS_ENABLE)
            begin
                st_next.enable = reg_wdata[eirq_pkg::STAT_W-1:0];
            end
            else if (reg_addr == eirq_pkg::OFS_CLEAR)
            begin
                clr = reg_wdata[eirq_pkg::STAT_W-1:0];
            end
        end
        // a new event beats a clear in the same cycle
        st_next.status = (st_reg.status & ~clr) | ev;
        st_next.irq = |(st_next.status & st_next.enable);

        // register reads, data only in the following cycle
        st_next.rdata = '0;
        if (reg_rd)
        begin
            if (reg_addr == eirq_pkg::OFS_CONFIG)
            begin
                st_next.rdata = st_reg.cfg;
            end
            else if (reg_addr == eirq_pkg::OFS_STATUS)
            begin
                st_next.rdata = {11'h000, st_reg.status};
            end
            else if (reg_addr == eirq_pkg::OFS_ENABLE)
            begin
                st_next.rdata = {11'h000, st_reg.enable};
            end
            else if (reg_addr == eirq_pkg::OFS_LEVEL)
            begin
                st_next.rdata = {12'h000, st_reg.stable};
            end
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
            st_reg.cfg <= eirq_pkg::CONFIG_RESET;
            st_reg.rx_sync <= 3'h7;
            st_reg.rx_level <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ======================================================================
    // outputs
    assign reg_rdata = st_reg.rdata;
    assign ext_event_line_0 = st_reg.evt[0];
    assign ext_event_line_1 = st_reg.evt[1];
    assign ext_event_line_2 = st_reg.evt[2];
    assign ext_event_line_3 = st_reg.evt[3];
    assign irq = st_reg.irq;
    assign wake_req = st_reg.wake;
    assign rx_pass_valid = st_reg.rxv;
    assign rx_pass_data = st_reg.rxd;
    assign pwm_capable_pin_out = st_reg.pin_out;
    assign pwm_capable_pin_oe = st_reg.pin_oe;

    // ======================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic rdy_q;
    assign rdy_q = (st_reg.init_cnt == eirq_pkg::INIT_DONE);

    property p_line0;
        ##1 $past(rdy_q) |-> st_reg.evt[0] ==
            (($fell(st_reg.stable[0]) && $past(st_reg.cfg[0]))
            || ($rose(st_reg.stable[0]) && $past(st_reg.cfg[1])));
    endproperty
    a_line0: assert property (p_line0)
        else $error("line 0 event mismatch");

    property p_line1;
        ##1 $past(rdy_q) |-> st_reg.evt[1] ==
            (($fell(st_reg.stable[1]) && $past(st_reg.cfg[2]))
            || ($rose(st_reg.stable[1]) && $past(st_reg.cfg[3])));
    endproperty
    a_line1: assert property (p_line1)
        else $error("line 1 event mismatch");

    property p_line2;
        ##1 $past(rdy_q) |-> st_reg.evt[2] ==
            (($fell(st_reg.stable[2]) && $past(st_reg.cfg[4]))
            || ($rose(st_reg.stable[2]) && $past(st_reg.cfg[5])));
    endproperty
    a_line2: assert property (p_line2)
        else $error("line 2 event mismatch");

    property p_line3;
        ##1 $past(rdy_q) |-> st_reg.evt[3] ==
            (($fell(st_reg.stable[3]) && $past(st_reg.cfg[6]))
            || ($rose(st_reg.stable[3]) && $past(st_reg.cfg[7])));
    endproperty
    a_line3: assert property (p_line3)
        else $error("line 3 event mismatch");

    property p_no_edge_bits;
        st_reg.cfg[1:0] == 2'h0 |=> !st_reg.evt[0];
    endproperty
    a_no_edge_bits: assert property (p_no_edge_bits)
        else $error("line 0 fired with no edge selected");

    property p_deb_hold;
        $past(st_reg.cfg[eirq_pkg::BIT_DEBOUNCE]) && $past(rdy_q)
            && $changed(st_reg.stable[0])
            |-> $past(st_reg.cnt[0]) == DEB_LAST;
    endproperty
    a_deb_hold: assert property (p_deb_hold)
        else $error("debounced level moved before interval");

    property p_fast_pulse;
        rdy_q && !st_reg.cfg[eirq_pkg::BIT_DEBOUNCE]
            && st_reg.sync1[1] == st_reg.sync2[1]
            |=> st_reg.stable[1] == $past(st_reg.sync2[1]);
    endproperty
    a_fast_pulse: assert property (p_fast_pulse)
        else $error("undebounced level not taken");

    property p_wake;
        $fell(st_reg.rx_level) && $past(low_power)
            && $past(st_reg.cfg[eirq_pkg::BIT_UART_WAKE]) |-> wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on receive activity");

    logic wake_pend;
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            wake_pend <= 1'b0;
        else
            wake_pend <= wake_req | (wake_pend & ~rx_char_valid);
    property p_discard;
        wake_pend && rx_char_valid |=> !rx_pass_valid;
    endproperty
    a_discard: assert property (p_discard)
        else $error("first character after wake passed on");

    property p_pwm;
        st_reg.cfg[eirq_pkg::BIT_PWM_SEL]
            |=> pwm_capable_pin_oe && pwm_capable_pin_out == $past(pwm_in);
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("pwm not routed to pin");

    c_event: cover property (ext_event_line_0 ##[1:50] ext_event_line_0);
    c_wake_drop: cover property (wake_req ##[1:60] (rx_char_valid
        && st_reg.discard));
    c_deb_accept: cover property (st_reg.cfg[eirq_pkg::BIT_DEBOUNCE]
        && st_reg.cnt[0] == DEB_LAST);
    c_min_pulse: cover property (rdy_q && st_reg.sync2[1]
        ##1 !st_reg.sync2[1] [*8] ##1 !st_reg.sync2[1]);

endmodule : eirq_edge_config

`default_nettype wire

//--- verif/eirq_pin_source.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// far side: pin drivers, asynchronous to the block clock
module eirq_pin_source (
    // levels asked for by the bench
    input wire logic [4:0] lvl,
    // event pins 0..3, serial receive pin 4
    output logic [4:0] pin
);
    // skew keeps pin changes away from the sampling edge
    always @(lvl)
    begin
        pin <= #7 lvl;
    end

    // pins idle high, serial line idle high too
    initial
    begin
        pin = 5'h1F;
    end
endmodule : eirq_pin_source

`default_nettype wire

//--- verif/ext_irq_edge_config_test.sv
`timescale 1ns/1ps
`default_nettype none

module ext_irq_edge_config_test;
    logic clk;
    logic rst_b;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic [4:0] lvl;
    logic [4:0] pin;
    logic [3:0] ev;
    logic irq;
    logic low_power;
    logic rx_char_valid;
    logic [7:0] rx_char_data;
    logic wake_req;
    logic rx_pass_valid;
    logic [7:0] rx_pass_data;
    logic pwm_in;
    logic gpio_out;
    logic gpio_oe;
    logic pin_out;
    logic pin_oe;
    int ev_cnt[4];
    int wake_cnt;
    int pass_cnt;
    logic [7:0] pass_d;
    int n_fail;
    int check_count;
    logic [31:0] seed;

    eirq_edge_config #(.DEB_CYC(8)) i_eirq_edge_config (
        .clk(clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_a_pin_0(pin[0]), .port_a_pin_1(pin[1]),
        .port_b_pin_0(pin[2]), .port_b_pin_6(pin[3]),
        .ext_event_line_0(ev[0]), .ext_event_line_1(ev[1]),
        .ext_event_line_2(ev[2]), .ext_event_line_3(ev[3]), .irq(irq),
        .uart_rx_pin(pin[4]), .low_power(low_power),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .wake_req(wake_req), .rx_pass_valid(rx_pass_valid),
        .rx_pass_data(rx_pass_data), .pwm_in(pwm_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .pwm_capable_pin_out(pin_out),
        .pwm_capable_pin_oe(pin_oe)
    );

    eirq_pin_source i_eirq_pin_source (.lvl(lvl), .pin(pin));

    always #25 clk = ~clk;

    // ======================================================================
    // output monitors
    always @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
            if (ev[i] === 1'b1) ev_cnt[i]++;
        if (wake_req === 1'b1) wake_cnt++;
        if (rx_pass_valid === 1'b1) pass_cnt++;
        if (rx_pass_valid === 1'b1) pass_d <= rx_pass_data;
    end

    // ======================================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // one fall and one rise per pulse
    function automatic logic [15:0] exp_edges(input logic [1:0] m);
        return 16'(m[0]) + 16'(m[1]);
    endfunction : exp_edges

    function automatic int ev_sum();
        return ev_cnt[0] + ev_cnt[1] + ev_cnt[2] + ev_cnt[3];
    endfunction : ev_sum

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp,
        input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata, exp);
        @(posedge clk);
    endtask : rd

    // low pulse of w cycles, then settle time
    task automatic pulse(input int i, input int w);
        lvl[i] <= 1'b0;
        cyc(w);
        lvl[i] <= 1'b1;
        cyc(24);
    endtask : pulse

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // ======================================================================
    // stimulus
    initial
    begin
        int b;
        int s;
        logic [15:0] cfg;
        logic [7:0] d;
        clk = 1'b0;
        rst_b = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        lvl = 5'h1F;
        low_power = 1'b0;
        rx_char_valid = 1'b0;
        rx_char_data = 8'h00;
        pwm_in = 1'b0;
        gpio_out = 1'b0;
        gpio_oe = 1'b0;
        seed = 32'h0000A35B;
        cyc(6);
        rst_b <= 1'b1;
        cyc(4);
        rd(eirq_pkg::OFS_CONFIG, eirq_pkg::CONFIG_RESET, "config reset");
        rd(4'hF, 16'h0000, "unmapped read");
        rd(eirq_pkg::OFS_LEVEL, 16'h000F, "idle level");
        wr(eirq_pkg::OFS_ENABLE, 16'h001F);
        rd(eirq_pkg::OFS_ENABLE, 16'h001F, "enable");
        for (int i = 0; i < 4; i++)
            for (int m = 0; m < 4; m++)
            begin
                b = ev_cnt[i];
                s = ev_sum();
                cfg = 16'(rnd()) & 16'h00FF;
                cfg[2*i +: 2] = m[1:0];
                wr(eirq_pkg::OFS_CONFIG, cfg);
                pulse(i, 9 + int'(rnd() % 4));
                check("line count", 16'(ev_cnt[i] - b), exp_edges(m[1:0]));
                check("all lines", 16'(ev_sum() - s), exp_edges(m[1:0]));
            end
        check("irq", 16'(irq), 16'h0001);
        rd(eirq_pkg::OFS_STATUS, 16'h000F, "status");
        wr(eirq_pkg::OFS_CLEAR, 16'h001F);
        wr(eirq_pkg::OFS_ENABLE, 16'h0000);
        wr(eirq_pkg::OFS_CONFIG, 16'h0001);
        pulse(0, 9);
        check("masked irq", 16'(irq), 16'h0000);
        rd(eirq_pkg::OFS_STATUS, 16'h0001, "status after clear");
        // debounce: short glitch dropped, long low accepted
        wr(eirq_pkg::OFS_CONFIG, 16'h0101);
        b = ev_cnt[0];
        pulse(0, 5);
        check("glitch", 16'(ev_cnt[0] - b), 16'h0000);
        pulse(0, 20);
        check("debounced", 16'(ev_cnt[0] - b), 16'h0001);
        low_power <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            b = wake_cnt;
            wr(eirq_pkg::OFS_CONFIG, k[0] ? 16'h0200 : 16'h0000);
            pulse(4, 10);
            check("wake", 16'(wake_cnt - b), 16'(k));
        end
        low_power <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            d = 8'(rnd());
            rx_char_valid <= 1'b1;
            rx_char_data <= d;
            cyc(1);
            rx_char_valid <= 1'b0;
            cyc(4);
            check("passed chars", 16'(pass_cnt), 16'(k));
        end
        check("passed data", 16'(pass_d), 16'(d));
        for (int k = 0; k < 2; k++)
        begin
            wr(eirq_pkg::OFS_CONFIG, 16'(k) << 15);
            // sources disagree so a wrong mux path shows
            pwm_in <= k[0];
            gpio_out <= ~k[0];
            gpio_oe <= ~k[0];
            cyc(3);
            check("pwm pin", 16'({pin_oe, pin_out}), 16'h0003);
        end
        test_done();
    end

    // watchdog well past the expected run length
    initial
    begin
        cyc(20000);
        n_fail++;
        test_done();
    end
endmodule : ext_irq_edge_config_test

`default_nettype wire
